// *** src/flash_program_erase_control.sv ***
// register front end and mode sequencing for flash program and erase
module flash_program_erase_control #(
  parameter int unsigned BLOCKS = flash_ctl_pkg::BLOCK_COUNT
) (
  // clock, reset, enable
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic              ce,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // flash array result
  input  wire logic              array_fault,
  // mode controls to the array
  output logic                   write_enable_gate,
  output logic                   erase_setup,
  output logic                   program_setup,
  output logic                   erase_verify,
  output logic                   program_verify,
  output logic                   erase_mode,
  output logic                   program_mode,
  output logic                   op_error_flag,
  output logic                   ctrl_reg_access_enable,
  // erase target
  output logic      [BLOCKS-1:0] block_sel,
  output logic      [15:0]       erase_base,
  output logic      [15:0]       erase_limit,
  output logic                   erase_target_valid
);

  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] ofs,
                                   input logic       strobe);
    return strobe && (addr == ofs);
  endfunction : reg_hit

  logic              gate_q;
  logic              gate_d;
  logic              esetup_q;
  logic              psetup_q;
  logic              everify_q;
  logic              pverify_q;
  logic              erase_q;
  logic              program_q;
  logic              error_q;
  logic              access_q;
  logic [BLOCKS-1:0] block_q;
  logic [BLOCKS-1:0] block_kept;
  logic              block_multi;
  logic [15:0]       base_d;
  logic [15:0]       limit_d;
  logic              any_d;
  logic [15:0]       base_q;
  logic [15:0]       limit_q;
  logic              any_q;
  logic [7:0]        rdata_q;
  logic [7:0]        rd_mux;
  logic              wr_mode;
  logic              wr_block;
  logic              wr_access;
  logic              fault_evt;
  logic              protect;
  logic              may_set;

  // register decode, mode and block writes gated by the access enable
  assign wr_mode   = access_q &&
                     reg_hit(reg_addr, flash_ctl_pkg::MODE_CTRL_OFS,
                             reg_wr);
  assign wr_block  = access_q &&
                     reg_hit(reg_addr, flash_ctl_pkg::BLOCK_SEL_OFS,
                             reg_wr);
  assign wr_access = reg_hit(reg_addr, flash_ctl_pkg::ACCESS_EN_OFS,
                             reg_wr);
  // status writes fall through with no effect

  // failure only counts while an operation runs
  assign fault_evt = array_fault && (program_q || erase_q);
  assign protect   = error_q || fault_evt;
  assign may_set   = wr_mode && gate_q;

  always_comb
  begin
    gate_d = gate_q;
    if (wr_mode)
      gate_d = reg_wdata[flash_ctl_pkg::GATE_BIT];
  end

  // access enable register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      access_q <= flash_ctl_pkg::ACCESS_EN_RST;
    else if (ce && wr_access)
      access_q <= reg_wdata[flash_ctl_pkg::ACCESS_BIT];
  end

  // write enable gate
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      gate_q <= flash_ctl_pkg::MODE_CTRL_RST[flash_ctl_pkg::GATE_BIT];
    else if (ce)
      gate_q <= gate_d;
  end

  // setup states
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      esetup_q <= flash_ctl_pkg::MODE_CTRL_RST[flash_ctl_pkg::ESETUP_BIT];
      psetup_q <= flash_ctl_pkg::MODE_CTRL_RST[flash_ctl_pkg::PSETUP_BIT];
    end
    else if (ce)
    begin
      if (!gate_d || protect)
      begin
        esetup_q <= 1'b0;
        psetup_q <= 1'b0;
      end
      else if (may_set)
      begin
        esetup_q <= reg_wdata[flash_ctl_pkg::ESETUP_BIT];
        psetup_q <= reg_wdata[flash_ctl_pkg::PSETUP_BIT];
      end
    end
  end

  // erase and program modes
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      erase_q   <= flash_ctl_pkg::MODE_CTRL_RST[flash_ctl_pkg::ERASE_BIT];
      program_q <= flash_ctl_pkg::MODE_CTRL_RST[flash_ctl_pkg::PROGRAM_BIT];
    end
    else if (ce)
    begin
      if (!gate_d || protect)
      begin
        erase_q   <= 1'b0;
        program_q <= 1'b0;
      end
      else if (may_set)
      begin
        // entry needs the matching setup already held
        erase_q   <= reg_wdata[flash_ctl_pkg::ERASE_BIT] &&
                     esetup_q;
        program_q <= reg_wdata[flash_ctl_pkg::PROGRAM_BIT] &&
                     psetup_q;
      end
    end
  end

  // verify modes stay usable under error protection
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      everify_q <= flash_ctl_pkg::MODE_CTRL_RST[flash_ctl_pkg::EVERIFY_BIT];
      pverify_q <= flash_ctl_pkg::MODE_CTRL_RST[flash_ctl_pkg::PVERIFY_BIT];
    end
    else if (ce)
    begin
      if (!gate_d)
      begin
        everify_q <= 1'b0;
        pverify_q <= 1'b0;
      end
      else if (may_set)
      begin
        everify_q <= reg_wdata[flash_ctl_pkg::EVERIFY_BIT];
        pverify_q <= reg_wdata[flash_ctl_pkg::PVERIFY_BIT];
      end
    end
  end

  // error flag, cleared by reset only
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      error_q <= flash_ctl_pkg::ERROR_RST;
    else if (ce && fault_evt)
      error_q <= 1'b1;
  end

  block_select_filter #(
    .BLOCKS    (BLOCKS)
  ) u_filter (
    .wr_bits   (reg_wdata[BLOCKS-1:0]),
    .kept_bits (block_kept),
    .multi_sel (block_multi)
  );

  // erase block select
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      block_q <= flash_ctl_pkg::BLOCK_SEL_RST[BLOCKS-1:0];
    else if (ce)
    begin
      if (!gate_d)
        block_q <= '0;
      else if (wr_block && gate_q)
        block_q <= block_kept;
    end
  end

  block_range_decode #(
    .BLOCKS  (BLOCKS)
  ) u_range (
    .sel     (block_q),
    .base    (base_d),
    .limit   (limit_d),
    .any_sel (any_d)
  );

  // registered erase span
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      base_q  <= 16'h0000;
      limit_q <= 16'h0000;
      any_q   <= 1'b0;
    end
    else if (ce)
    begin
      base_q  <= base_d;
      limit_q <= limit_d;
      any_q   <= any_d;
    end
  end

  // read multiplexer
  always_comb
  begin
    rd_mux = flash_ctl_pkg::READ_IDLE;
    if (reg_addr == flash_ctl_pkg::ACCESS_EN_OFS)
      rd_mux[flash_ctl_pkg::ACCESS_BIT] = access_q;
    else if (access_q)
    begin
      unique case (reg_addr)
        flash_ctl_pkg::MODE_CTRL_OFS:
        begin
          // bit 7 left at zero
          rd_mux[flash_ctl_pkg::GATE_BIT]    = gate_q;
          rd_mux[flash_ctl_pkg::ESETUP_BIT]  = esetup_q;
          rd_mux[flash_ctl_pkg::PSETUP_BIT]  = psetup_q;
          rd_mux[flash_ctl_pkg::EVERIFY_BIT] = everify_q;
          rd_mux[flash_ctl_pkg::PVERIFY_BIT] = pverify_q;
          rd_mux[flash_ctl_pkg::ERASE_BIT]   = erase_q;
          rd_mux[flash_ctl_pkg::PROGRAM_BIT] = program_q;
        end
        flash_ctl_pkg::PROG_STATUS_OFS:
          rd_mux[flash_ctl_pkg::ERROR_BIT] = error_q;
        flash_ctl_pkg::BLOCK_SEL_OFS:
          rd_mux[BLOCKS-1:0] = block_q;
        default:
          rd_mux = flash_ctl_pkg::READ_IDLE;
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      rdata_q <= flash_ctl_pkg::READ_IDLE;
    else if (ce)
      rdata_q <= reg_rd ? rd_mux : flash_ctl_pkg::READ_IDLE;
  end

  assign reg_rdata              = rdata_q;
  assign write_enable_gate      = gate_q;
  assign erase_setup            = esetup_q;
  assign program_setup          = psetup_q;
  assign erase_verify           = everify_q;
  assign program_verify         = pverify_q;
  assign erase_mode             = erase_q;
  assign program_mode           = program_q;
  assign op_error_flag          = error_q;
  assign ctrl_reg_access_enable = access_q;
  assign block_sel              = block_q;
  assign erase_base             = base_q;
  assign erase_limit            = limit_q;
  assign erase_target_valid     = any_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  a_gate_low_refuse:
    assert property (!gate_q && ce |=>
                     !(esetup_q || psetup_q || erase_q || program_q ||
                       everify_q || pverify_q))
    else $error("mode bit set while gate was low");

  a_erase_setup_follow:
    assert property (ce && may_set && !protect && gate_d |=>
                     esetup_q == $past(reg_wdata[5]))
    else $error("erase setup did not follow write");

  a_erase_entry_cond:
    assert property ($rose(erase_q) |->
                     $past(gate_q) && $past(esetup_q) &&
                     $past(reg_wdata[1]) && $past(wr_mode))
    else $error("erase mode entered without gate and setup");

  a_prog_setup_follow:
    assert property (ce && may_set && !protect && gate_d |=>
                     psetup_q == $past(reg_wdata[4]))
    else $error("program setup did not follow write");

  a_prog_entry_cond:
    assert property ($rose(program_q) |->
                     $past(gate_q) && $past(psetup_q) &&
                     $past(reg_wdata[0]) && $past(wr_mode))
    else $error("program mode entered without gate and setup");

  a_erase_verify_follow:
    assert property (ce && may_set && gate_d |=>
                     everify_q == $past(reg_wdata[3]))
    else $error("erase verify did not follow write");

  a_prog_verify_follow:
    assert property (ce && may_set && gate_d |=>
                     pverify_q == $past(reg_wdata[2]))
    else $error("program verify did not follow write");

  a_error_protects:
    assert property (ce && fault_evt |=>
                     error_q && !erase_q && !program_q &&
                     !esetup_q && !psetup_q)
    else $error("fault did not raise error protection");

  a_block_held_zero:
    assert property (!gate_q |-> block_q == '0)
    else $error("block select nonzero while gate low");

  a_block_one_hot:
    assert property ($countones(block_q) <= 1)
    else $error("more than one erase block selected");

  a_status_reserved:
    assert property (ce && reg_rd &&
                     reg_addr == flash_ctl_pkg::PROG_STATUS_OFS |=>
                     reg_rdata[6:0] == 7'h00)
    else $error("status reserved bits read nonzero");

  a_access_gated:
    assert property (!access_q && reg_wr && !fault_evt |=>
                     $stable({gate_q, esetup_q, psetup_q, block_q}))
    else $error("control register changed with access disabled");

  a_span_register:
    assert property (ce && block_q == 7'h10 |=>
                     erase_base == 16'h1000 && erase_limit == 16'h7fff)
    else $error("block 4 span wrong");

  a_decode_span:
    assert property (block_q == 7'h40 |->
                     base_d == 16'hc000 && limit_d == 16'hdfff)
    else $error("block 6 span decoded wrong");

endmodule : flash_program_erase_control

// *** src/flash_ctl_pkg.sv ***
// constants for the flash program/erase control block
// Functional notes
// - write enable gate bit 6 low refuses setting other mode or block bits
// - erase setup bit 5 enters erase setup, clearing it cancels
// - erase bit 1 takes effect only with gate and erase setup high
// - program setup bit 4 enters program setup, clearing it cancels
// - program bit 0 takes effect only with gate and program setup high
// - erase verify bit 3 enters erase verify, clearing it leaves
// - program verify bit 2 enters program verify, clearing it leaves
// - failed operation sets error flag bit 7 and forces error protection
// - block select register held at zero while gate is low
// - write leaving several block bits set clears whole register
// - block bits 0 to 3 select 1 kbyte blocks from 0x0000 up
// - block bit 4 selects 0x1000 through 0x7fff
// - block bit 5 selects 0x8000 through 0xbfff
// - block bit 6 selects 0xc000 through 0xdfff
// - reserved bit 7 of mode and block registers reads zero
// - reserved bits 6 to 0 of status register read zero
// - control registers accessible only while access enable bit is 1
package flash_ctl_pkg;

  // register offsets
  localparam logic [7:0] MODE_CTRL_OFS   = 8'h00;
  localparam logic [7:0] PROG_STATUS_OFS = 8'h01;
  localparam logic [7:0] BLOCK_SEL_OFS   = 8'h02;
  localparam logic [7:0] ACCESS_EN_OFS   = 8'h03;

  // mode control fields
  localparam int unsigned PROGRAM_BIT   = 0;
  localparam int unsigned ERASE_BIT     = 1;
  localparam int unsigned PVERIFY_BIT   = 2;
  localparam int unsigned EVERIFY_BIT   = 3;
  localparam int unsigned PSETUP_BIT    = 4;
  localparam int unsigned ESETUP_BIT    = 5;
  localparam int unsigned GATE_BIT      = 6;
  // status and access fields
  localparam int unsigned ERROR_BIT     = 7;
  localparam int unsigned ACCESS_BIT    = 7;

  // reset values
  localparam logic [7:0] MODE_CTRL_RST  = 8'h00;
  localparam logic [7:0] BLOCK_SEL_RST  = 8'h00;
  localparam logic       ERROR_RST      = 1'b0;
  localparam logic       ACCESS_EN_RST  = 1'b0;
  localparam logic [7:0] READ_IDLE      = 8'h00;

  // erase blocks
  localparam int unsigned BLOCK_COUNT   = 7;
  localparam logic [15:0] BLOCK_BASE [BLOCK_COUNT] = '{
    16'h0000, 16'h0400, 16'h0800, 16'h0c00, 16'h1000, 16'h8000, 16'hc000};
  localparam logic [15:0] BLOCK_LIMIT [BLOCK_COUNT] = '{
    16'h03ff, 16'h07ff, 16'h0bff, 16'h0fff, 16'h7fff, 16'hbfff, 16'hdfff};

endpackage : flash_ctl_pkg

// *** src/block_select_filter.sv ***
// screens a block select write for more than one set bit
module block_select_filter #(
  parameter int unsigned BLOCKS = flash_ctl_pkg::BLOCK_COUNT
) (
  // written value
  input  wire logic [BLOCKS-1:0] wr_bits,
  // value to store
  output logic      [BLOCKS-1:0] kept_bits,
  output logic                   multi_sel
);

  function automatic logic several_set(input logic [BLOCKS-1:0] v);
    logic seen;
    logic more;
    seen = 1'b0;
    more = 1'b0;
    for (int i = 0; i < BLOCKS; i++)
    begin
      more = more | (seen & v[i]);
      seen = seen | v[i];
    end
    return more;
  endfunction : several_set

  assign multi_sel = several_set(wr_bits);
  // several bits at once wipe the register
  assign kept_bits = multi_sel ? '0 : wr_bits;

endmodule : block_select_filter

// *** src/block_range_decode.sv ***
// turns the one-hot block select into the erase address span
module block_range_decode #(
  parameter int unsigned BLOCKS = flash_ctl_pkg::BLOCK_COUNT
) (
  // one-hot selection
  input  wire logic [BLOCKS-1:0] sel,
  // selected span
  output logic      [15:0]       base,
  output logic      [15:0]       limit,
  output logic                   any_sel
);

  logic [15:0] base_acc  [BLOCKS+1];
  logic [15:0] limit_acc [BLOCKS+1];

  assign base_acc[0]  = 16'h0000;
  assign limit_acc[0] = 16'h0000;

  generate
    for (genvar i = 0; i < BLOCKS; i++)
    begin : g_blk
      assign base_acc[i+1]  = base_acc[i] |
        (sel[i] ? flash_ctl_pkg::BLOCK_BASE[i] : 16'h0000);
      assign limit_acc[i+1] = limit_acc[i] |
        (sel[i] ? flash_ctl_pkg::BLOCK_LIMIT[i] : 16'h0000);
    end
  endgenerate

  assign base    = base_acc[BLOCKS];
  assign limit   = limit_acc[BLOCKS];
  assign any_sel = |sel;

endmodule : block_range_decode

// *** test/flash_program_erase_control_tb_top.sv ***
// self-checking bench for the flash program/erase control block
module flash_program_erase_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0]  MODE = 8'h00;
  localparam logic [7:0]  STAT = 8'h01;
  localparam logic [7:0]  BSEL = 8'h02;
  localparam logic [7:0]  AEN  = 8'h03;
  // expected erase spans, one per block bit
  localparam logic [15:0] SPAN_LO [7] = '{16'h0000, 16'h0400, 16'h0800,
    16'h0c00, 16'h1000, 16'h8000, 16'hc000};
  localparam logic [15:0] SPAN_HI [7] = '{16'h03ff, 16'h07ff, 16'h0bff,
    16'h0fff, 16'h7fff, 16'hbfff, 16'hdfff};
  // written value, then expected readback
  localparam logic [15:0] MODE_TAB [15] = '{16'h4040, 16'hc040, 16'h6060,
    16'h6262, 16'h6060, 16'h4040, 16'h4240, 16'h5050, 16'h5151, 16'h5050,
    16'h4040, 16'h4140, 16'h4848, 16'h4444, 16'h4040};

  logic        ref_clk;
  logic        srst;
  logic        ce;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        array_fault;
  logic        write_enable_gate;
  logic        erase_setup;
  logic        program_setup;
  logic        erase_verify;
  logic        program_verify;
  logic        erase_mode;
  logic        program_mode;
  logic        op_error_flag;
  logic        ctrl_reg_access_enable;
  logic [6:0]  block_sel;
  logic [15:0] erase_base;
  logic [15:0] erase_limit;
  logic        erase_target_valid;
  logic [6:0]  mode_vec;
  logic [7:0]  exp_q [$];
  logic        rd_seen;
  logic [7:0]  v;
  int          miscompares;
  int          n_checks;

  assign mode_vec = {write_enable_gate, erase_setup, program_setup,
    erase_verify, program_verify, erase_mode, program_mode};

  flash_program_erase_control #(.BLOCKS(7)) dut_u (
    .ref_clk                (ref_clk),
    .srst                   (srst),
    .ce                     (ce),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .reg_rdata              (reg_rdata),
    .array_fault            (array_fault),
    .write_enable_gate      (write_enable_gate),
    .erase_setup            (erase_setup),
    .program_setup          (program_setup),
    .erase_verify           (erase_verify),
    .program_verify         (program_verify),
    .erase_mode             (erase_mode),
    .program_mode           (program_mode),
    .op_error_flag          (op_error_flag),
    .ctrl_reg_access_enable (ctrl_reg_access_enable),
    .block_sel              (block_sel),
    .erase_base             (erase_base),
    .erase_limit            (erase_limit),
    .erase_target_valid     (erase_target_valid)
  );

  always #12.5 ref_clk = ~ref_clk;

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // one bus cycle, launched right after a rising edge
  task automatic bus(input logic w, input logic r, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask : rd

  // release the bus and wait until outputs settle
  task automatic settle;
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    @(negedge ref_clk);
  endtask : settle

  // read data stand only in the cycle after the read strobe
  always @(posedge ref_clk)
  begin
    if (rd_seen)
      chk(40'(reg_rdata), 40'(exp_q.pop_front()));
    rd_seen <= reg_rd & ce & ~srst;
  end

  initial
  begin
    repeat (3000) @(posedge ref_clk);
    miscompares++;
    wrap_up();
  end

  initial
  begin
    ref_clk     = 1'b0;
    srst        = 1'b1;
    ce          = 1'b1;
    reg_addr    = 8'h00;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    array_fault = 1'b0;
    rd_seen     = 1'b0;
    miscompares = 0;
    n_checks    = 0;
    void'($urandom(32'habbb19c7));
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    settle();
    chk({op_error_flag, block_sel, mode_vec}, 40'h0);
    // access disabled: writes lost, reads zero
    rd(AEN, 8'h00);
    wr(MODE, 8'h40);
    wr(AEN, 8'h80);
    rd(AEN, 8'h80);
    rd(MODE, 8'h00);
    // gate low refuses every other bit
    wr(MODE, 8'h3f);
    wr(BSEL, 8'h01);
    rd(MODE, 8'h00);
    rd(BSEL, 8'h00);
    for (int i = 0; i < 15; i++)
    begin
      wr(MODE, MODE_TAB[i][15:8]);
      rd(MODE, MODE_TAB[i][7:0]);
      settle();
      chk(40'({ctrl_reg_access_enable, mode_vec}),
          40'({1'b1, MODE_TAB[i][6:0]}));
    end
    for (int i = 0; i < 7; i++)
    begin
      wr(BSEL, 8'h80 | (8'h01 << i));
      rd(BSEL, 8'h01 << i);
      settle();
      chk(40'({erase_target_valid, erase_base, erase_limit}),
          40'({1'b1, SPAN_LO[i], SPAN_HI[i]}));
      chk(40'(block_sel), 40'(8'h01 << i));
      v = 8'($urandom);
      if ($countones(v[6:0]) < 2)
        v = v | 8'h41;
      wr(BSEL, v);
      rd(BSEL, 8'h00);
      settle();
      chk({erase_target_valid, block_sel}, 40'h0);
    end
    // dropping the gate clears the selection
    wr(BSEL, 8'h20);
    wr(MODE, 8'h00);
    rd(BSEL, 8'h00);
    wr(BSEL, 8'h04);
    rd(BSEL, 8'h00);
    settle();
    chk({block_sel, mode_vec}, 40'h0);
    // status reads zero, fault during programming
    rd(STAT, 8'h00);
    wr(MODE, 8'h40);
    wr(MODE, 8'h50);
    wr(MODE, 8'h51);
    settle();
    chk(40'(program_mode), 40'h1);
    @(posedge ref_clk);
    array_fault <= 1'b1;
    @(posedge ref_clk);
    array_fault <= 1'b0;
    rd(STAT, 8'h80);
    rd(MODE, 8'h40);
    wr(MODE, 8'h50);
    wr(MODE, 8'h51);
    rd(MODE, 8'h40);
    rd(STAT, 8'h80);
    // clock enable low freezes state
    settle();
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(MODE, 8'h00);
    settle();
    @(posedge ref_clk);
    ce <= 1'b1;
    rd(MODE, 8'h40);
    // access off again, unmapped place
    wr(AEN, 8'h00);
    rd(MODE, 8'h00);
    wr(8'h7f, 8'hff);
    rd(8'h7f, 8'h00);
    settle();
    // second reset clears the sticky error
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    settle();
    chk({op_error_flag, mode_vec}, 40'h0);
    wrap_up();
  end
endmodule : flash_program_erase_control_tb_top
